// ### sdipm_poll.sv
// sdipm_poll: sdi-12 sensor poll master with ahb-lite registers
// assumes one ahb-lite master and one sensor wire with pull
//
// Functional notes
// - sensor address only zero through nine
// - power sensor only when measurement due
// - pre-power 0..63750 ms in 250 ms
// - send chosen measurement command M (index zero) or M1..M9
// - wait announced delay before any data request
// - issue data requests until all values fetched
// - reading index one picks first value
// - ascii decimal scaled by resolution setting
// - each slot stores into its own result
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sdipm_poll
  import sdipm_pkg::*;
#(
  parameter int BitCyc = BIT_CYC,
  parameter int BreakCyc = BREAK_CYC,
  parameter int MarkCyc = MARK_CYC,
  parameter int StepCyc = STEP_CYC,
  parameter int SecCyc = SEC_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // sdi-12 wire
  input wire logic sdiIn,
  output logic sdiOut,
  output logic sdiOe,
  // sensor supply switch
  output logic sensorPower
);
  // bus state
  logic wrPend; // write data phase due
  logic [7:0] wAddr; // latched write offset
  logic [31:0] rdMux; // read value
  // registers
  sdipm_cfg_t cfgReg; // software config
  sdipm_cfg_t run; // config held for a poll
  logic startReg; // start pulse
  logic doneReg; // poll finished, sticky
  logic errReg; // poll failed, sticky
  logic ovrReg; // char lost, sticky
  logic [31:0] resultReg [NSLOT]; // per-slot values
  // sequencer
  sdipm_state_t state;
  logic [31:0] tmr; // cycle timer
  logic [9:0] cnt; // steps or seconds left
  logic isData; // current command is a data request
  logic [3:0] dIdx; // data request number
  logic [1:0] chIdx; // char being sent
  logic lastSent; // final char handed to the line
  logic [31:0] tmo; // reply timeout
  // parser
  logic firstCh; // next char is the address
  logic [1:0] digCnt; // ack digits taken
  logic [9:0] delaySec; // announced delay
  logic [3:0] nVal; // announced value count
  logic [3:0] valTotal; // values seen over replies
  logic [3:0] replyVals; // values in this reply
  logic inSel; // inside selected value
  logic got; // selected value found
  logic neg; // selected value sign
  logic seenPt; // decimal point passed
  logic [1:0] fracCnt; // fraction digits kept
  logic [31:0] acc; // scaled magnitude
  // line and fifo wiring
  logic txValid, txReady, rxValid;
  logic [6:0] txData;
  sdipm_char_t rxChar, fifoChar;
  logic fifoInReady, fifoValid, fifoReady;
  logic [2:0] sendLen;
  logic [3:0] dig;
  logic isDig;
  logic take;

  // character engine on the wire
  sdipm_line #(
    .BitCyc(BitCyc)
  ) uLine (
    .clk(clk),
    .rst(rst),
    .sdiIn(sdiIn),
    .sdiOut(sdiOut),
    .sdiOe(sdiOe),
    .brk(state == ST_BRK),
    .hold(state == ST_MARK || state == ST_SEND),
    .txValid(txValid),
    .txData(txData),
    .txReady(txReady),
    .rxValid(rxValid),
    .rxChar(rxChar)
  );

  // received chars queue for the parser
  sdipm_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) uFifo (
    .clk(clk),
    .rst(rst),
    .inValid(rxValid),
    .inData(rxChar),
    .inReady(fifoInReady),
    .outValid(fifoValid),
    .outData(fifoChar),
    .outReady(fifoReady)
  );

  // parser drains only while listening or waiting
  assign fifoReady = state == ST_RECV || state == ST_WAIT;
  assign take = fifoValid && state == ST_RECV;
  assign isDig = fifoChar.ch >= CH_ZERO && fifoChar.ch <= CH_NINE;
  assign dig = 4'(fifoChar.ch - CH_ZERO);

  // command length: plain M when index zero
  assign sendLen = (!isData && run.mIdx == '0) ? 3'd3 : 3'd4;

  // command characters: address, letter, digit, bang
  always_comb begin
    txData = CH_BANG;
    case (chIdx)
      2'd0: txData = 7'(CH_ZERO + run.addr);
      2'd1: txData = isData ? CH_D : CH_M;
      2'd2: begin
        if (sendLen == 3'd4) begin
          txData = 7'(CH_ZERO + (isData ? dIdx : run.mIdx));
        end
      end
      default: txData = CH_BANG;
    endcase
  end
  assign txValid = state == ST_SEND && txReady && !lastSent;

  // ahb address phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend <= 1'b0;
      wAddr <= '0;
    end else if (hready) begin
      wrPend <= hsel && htrans[1] && hwrite;
      wAddr <= haddr[7:0];
    end
  end

  // read decode, unmapped reads zero
  always_comb begin
    rdMux = '0;
    case (haddr[7:0])
      OFS_CFG: rdMux = 32'(cfgReg);
      OFS_STAT: begin
        rdMux[STAT_BUSY] = state != ST_IDLE;
        rdMux[STAT_DONE] = doneReg;
        rdMux[STAT_ERR] = errReg;
        rdMux[STAT_OVR] = ovrReg;
        rdMux[STAT_ST +: 8] = state;
      end
      default: begin
        if (haddr[7:4] == OFS_RES[7:4]) begin
          rdMux = resultReg[haddr[3:2]];
        end
      end
    endcase
  end

  // bus answers: zero wait, always okay
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // config register
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgReg <= sdipm_cfg_t'(CFG_RST);
    end else if (wrPend && wAddr == OFS_CFG) begin
      cfgReg <= sdipm_cfg_t'(hwdata[CFG_W-1:0]);
      // out-of-range address keeps old one
      if (hwdata[3:0] > MAX_ADDR) begin
        cfgReg.addr <= cfgReg.addr;
      end
    end
  end

  // start request from control write
  always_ff @(posedge clk) begin
    if (rst) begin
      startReg <= 1'b0;
    end else begin
      startReg <= wrPend && wAddr == OFS_CTRL && hwdata[CTRL_START];
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      doneReg <= 1'b0;
      errReg <= 1'b0;
      ovrReg <= 1'b0;
    end else begin
      if (wrPend && wAddr == OFS_STAT) begin
        if (hwdata[STAT_DONE]) begin
          doneReg <= 1'b0;
        end
        if (hwdata[STAT_ERR]) begin
          errReg <= 1'b0;
        end
        if (hwdata[STAT_OVR]) begin
          ovrReg <= 1'b0;
        end
      end
      if (state == ST_FIN && fracCnt >= run.res) begin
        doneReg <= 1'b1;
        if (!got) begin
          errReg <= 1'b1;
        end
      end
      if (rxValid && !fifoInReady) begin
        ovrReg <= 1'b1;
      end
    end
  end

  // per-slot result store
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NSLOT; i++) begin
        resultReg[i] <= '0;
      end
    end else if (state == ST_FIN && fracCnt >= run.res && got) begin
      resultReg[run.slot] <= neg ? 32'(-acc) : acc;
    end
  end

  // sensor supply switch
  always_ff @(posedge clk) begin
    if (rst) begin
      sensorPower <= 1'b0;
    end else if (state == ST_IDLE && startReg) begin
      sensorPower <= 1'b1;
    end else if (state == ST_FIN && fracCnt >= run.res) begin
      sensorPower <= 1'b0;
    end
  end

  // poll sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      run <= sdipm_cfg_t'(CFG_RST);
      tmr <= '0;
      cnt <= '0;
      isData <= 1'b0;
      dIdx <= '0;
      chIdx <= '0;
      tmo <= '0;
      lastSent <= 1'b0;
    end else begin
      case (state)
        // wait for software to start a poll
        ST_IDLE: begin
          if (startReg) begin
            run <= cfgReg;
            cnt <= 10'(cfgReg.preSteps);
            tmr <= 32'(StepCyc - 1);
            isData <= 1'b0;
            dIdx <= '0;
            state <= ST_POWER;
          end
        end
        // pre-power in 250 ms steps
        ST_POWER: begin
          if (cnt == '0) begin
            tmr <= 32'(BreakCyc - 1);
            state <= ST_BRK;
          end else if (tmr == '0) begin
            tmr <= 32'(StepCyc - 1);
            cnt <= 10'(cnt - 1'b1);
          end else begin
            tmr <= 32'(tmr - 1'b1);
          end
        end
        // break wakes the sensors
        ST_BRK: begin
          if (tmr == '0) begin
            tmr <= 32'(MarkCyc - 1);
            state <= ST_MARK;
          end else begin
            tmr <= 32'(tmr - 1'b1);
          end
        end
        // marking before the command
        ST_MARK: begin
          if (tmr == '0) begin
            chIdx <= '0;
            state <= ST_SEND;
          end else begin
            tmr <= 32'(tmr - 1'b1);
          end
        end
        // hand chars to the line one by one
        ST_SEND: begin
          if (txReady) begin
            if (lastSent) begin
              // line idle again after the final stop bit
              lastSent <= 1'b0;
              tmo <= 32'(BitCyc * TMO_BITS);
              state <= ST_RECV;
            end else if (3'(chIdx) == sendLen - 3'd1) begin
              lastSent <= 1'b1;
            end else begin
              chIdx <= 2'(chIdx + 1'b1);
            end
          end
        end
        // listen for the reply
        ST_RECV: begin
          tmo <= 32'(tmo - 1'b1);
          if (tmo == '0) begin
            state <= ST_FIN;
          end else if (take && fifoChar.ch == CH_LF) begin
            if (!isData) begin
              if (nVal == '0) begin
                state <= ST_FIN;
              end else begin
                cnt <= delaySec;
                tmr <= 32'(SecCyc - 1);
                state <= ST_WAIT;
              end
            end else if (valTotal >= nVal || replyVals == '0 || dIdx == MAX_DIDX) begin
              state <= ST_FIN;
            end else begin
              dIdx <= 4'(dIdx + 1'b1);
              tmr <= 32'(BreakCyc - 1);
              state <= ST_BRK;
            end
          end
        end
        // sit out the announced delay
        ST_WAIT: begin
          if (cnt == '0) begin
            isData <= 1'b1;
            dIdx <= '0;
            tmr <= 32'(BreakCyc - 1);
            state <= ST_BRK;
          end else if (tmr == '0) begin
            tmr <= 32'(SecCyc - 1);
            cnt <= 10'(cnt - 1'b1);
          end else begin
            tmr <= 32'(tmr - 1'b1);
          end
        end
        // pad fraction, store, drop power
        ST_FIN: begin
          if (fracCnt >= run.res) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // reply parser and value scaler
  always_ff @(posedge clk) begin
    if (rst || (state == ST_IDLE && startReg)) begin
      firstCh <= 1'b1;
      digCnt <= '0;
      delaySec <= '0;
      nVal <= '0;
      valTotal <= '0;
      replyVals <= '0;
      inSel <= 1'b0;
      got <= 1'b0;
      neg <= 1'b0;
      seenPt <= 1'b0;
      fracCnt <= '0;
      acc <= '0;
    end else if (state == ST_SEND) begin
      firstCh <= 1'b1;
      replyVals <= '0;
      inSel <= 1'b0;
    end else if (state == ST_FIN && fracCnt < run.res) begin
      // missing fraction digits count as zero
      acc <= 32'(acc * DEC_BASE);
      fracCnt <= 2'(fracCnt + 1'b1);
    end else if (take && !fifoChar.err) begin
      firstCh <= 1'b0;
      if (firstCh) begin
        firstCh <= 1'b0;
      end else if (!isData) begin
        // ack: three delay digits then value count
        if (isDig && digCnt != 2'd3) begin
          delaySec <= 10'(delaySec * DEC_BASE + dig);
          digCnt <= 2'(digCnt + 1'b1);
        end else if (isDig) begin
          nVal <= dig;
        end
      end else if (fifoChar.ch == CH_PLUS || fifoChar.ch == CH_MINUS) begin
        valTotal <= 4'(valTotal + 1'b1);
        replyVals <= 4'(replyVals + 1'b1);
        inSel <= 4'(valTotal + 1'b1) == run.readIdx;
        if (4'(valTotal + 1'b1) == run.readIdx) begin
          got <= 1'b1;
          neg <= fifoChar.ch == CH_MINUS;
          acc <= '0;
          seenPt <= 1'b0;
          fracCnt <= '0;
        end
      end else if (inSel && fifoChar.ch == CH_DOT) begin
        seenPt <= 1'b1;
      end else if (inSel && isDig) begin
        // keep fraction digits only up to resolution
        if (!seenPt) begin
          acc <= 32'(acc * DEC_BASE + dig);
        end else if (fracCnt < run.res) begin
          acc <= 32'(acc * DEC_BASE + dig);
          fracCnt <= 2'(fracCnt + 1'b1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sdipm_pkg.sv
// sdipm_pkg: timing, register map, config layout and states
// of the sdi-12 poll master; assumes a 200 MHz clock
package sdipm_pkg;
  // clock and line timing, each in its own unit
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD = 1200;
  localparam int BREAK_US = 12_000;
  localparam int MARK_US = 8_333;
  localparam int STEP_MS = 250;
  localparam int SEC_MS = 1000;
  localparam int TMO_BITS = 200;
  // derived cycle counts
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int BREAK_CYC = (CLK_HZ / 1_000_000) * BREAK_US;
  localparam int MARK_CYC = (CLK_HZ / 1_000_000) * MARK_US;
  localparam int STEP_CYC = (CLK_HZ / 1000) * STEP_MS;
  localparam int SEC_CYC = (CLK_HZ / 1000) * SEC_MS;
  // framing: start, 7 data, even parity, stop
  localparam int FRAME_BITS = 10;
  // sizes
  localparam int NSLOT = 4;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RES = 8'h10;
  // field positions
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_OVR = 3;
  localparam int STAT_ST = 8;
  localparam int CFG_W = 24;
  // limits and reset values
  localparam logic [3:0] MAX_ADDR = 4'h9;
  localparam logic [3:0] MAX_DIDX = 4'h9;
  localparam logic [31:0] DEC_BASE = 32'h0000_000a;
  localparam logic [23:0] CFG_RST = 24'h01_0000;
  // ascii characters used on the line
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_NINE = 7'h39;
  localparam logic [6:0] CH_M = 7'h4d;
  localparam logic [6:0] CH_D = 7'h44;
  localparam logic [6:0] CH_BANG = 7'h21;
  localparam logic [6:0] CH_PLUS = 7'h2b;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_DOT = 7'h2e;
  localparam logic [6:0] CH_LF = 7'h0a;
  // poll configuration as written by software
  typedef struct packed {
    logic [1:0] slot;
    logic [1:0] res;
    logic [3:0] readIdx;
    logic [7:0] preSteps;
    logic [3:0] mIdx;
    logic [3:0] addr;
  } sdipm_cfg_t;
  // one received character
  typedef struct packed {
    logic err;
    logic [6:0] ch;
  } sdipm_char_t;
  // poll sequencer states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_POWER = 8'h02,
    ST_BRK = 8'h04,
    ST_MARK = 8'h08,
    ST_SEND = 8'h10,
    ST_RECV = 8'h20,
    ST_WAIT = 8'h40,
    ST_FIN = 8'h80
  } sdipm_state_t;
endpackage

// ### sdipm_fifo.sv
// sdipm_fifo: synchronous valid/ready fifo
// assumes both sides on one clock
`timescale 1ns/10ps
`default_nettype none
module sdipm_fifo
  import sdipm_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage
  logic [AW-1:0] wrPtr; // write index
  logic [AW-1:0] rdPtr; // read index
  logic [AW:0] count; // fill level
  logic push;
  logic pop;
  // honest full and empty
  assign inReady = count != (AW+1)'(D);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
  // pointers and level
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (pop) begin
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ### sdipm_line.sv
// sdipm_line: 7e1 character engine for the sdi-12 wire
// assumes the pin level is raw and asynchronous
`timescale 1ns/10ps
`default_nettype none
module sdipm_line
  import sdipm_pkg::*;
#(
  parameter int BitCyc = BIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wire pin
  input wire logic sdiIn,
  output logic sdiOut,
  output logic sdiOe,
  // line control
  input wire logic brk,
  input wire logic hold,
  // transmit
  input wire logic txValid,
  input wire logic [6:0] txData,
  output logic txReady,
  // receive
  output logic rxValid,
  output sdipm_char_t rxChar
);
  logic s1, s2, s2Prev; // pin synchroniser
  logic [9:0] txSh; // transmit frame
  logic [3:0] txBits; // bits left to send
  logic [31:0] txTmr; // transmit bit timer
  logic [9:0] rxSh; // receive frame
  logic [3:0] rxBits; // bits taken
  logic [31:0] rxTmr; // receive bit timer
  logic rxAct; // frame in progress
  assign txReady = txBits == '0;
  assign rxChar.ch = rxSh[7:1];
  // stop low, parity odd or start high marks a bad char
  assign rxChar.err = !rxSh[9] || (^rxSh[8:1]) || rxSh[0];
  // two flops before any logic looks at the pin
  always_ff @(posedge clk) begin
    s1 <= sdiIn;
    s2 <= s1;
    s2Prev <= s2;
  end
  // transmit shifter, lsb first
  always_ff @(posedge clk) begin
    if (rst) begin
      txSh <= '1;
      txBits <= '0;
      txTmr <= '0;
    end else if (txReady && txValid) begin
      txSh <= {1'b1, ^txData, txData, 1'b0};
      txBits <= 4'(FRAME_BITS);
      txTmr <= 32'(BitCyc - 1);
    end else if (!txReady) begin
      if (txTmr == '0) begin
        txSh <= {1'b1, txSh[9:1]};
        txBits <= 4'(txBits - 1'b1);
        txTmr <= 32'(BitCyc - 1);
      end else begin
        txTmr <= 32'(txTmr - 1'b1);
      end
    end
  end
  // pin drive: break is spacing, otherwise marking or data
  always_ff @(posedge clk) begin
    if (rst) begin
      sdiOut <= 1'b1;
      sdiOe <= 1'b0;
    end else begin
      sdiOut <= brk ? 1'b0 : (txReady ? 1'b1 : txSh[0]);
      sdiOe <= brk || hold || !txReady;
    end
  end
  // receiver samples mid-bit, only while released
  always_ff @(posedge clk) begin
    if (rst) begin
      rxSh <= '0;
      rxBits <= '0;
      rxTmr <= '0;
      rxAct <= 1'b0;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!rxAct) begin
        if (!sdiOe && s2Prev && !s2) begin
          rxAct <= 1'b1;
          rxBits <= '0;
          rxTmr <= 32'(BitCyc / 2);
        end
      end else if (rxTmr == '0) begin
        rxSh <= {s2, rxSh[9:1]};
        rxTmr <= 32'(BitCyc - 1);
        rxBits <= 4'(rxBits + 1'b1);
        if (rxBits == 4'(FRAME_BITS - 1)) begin
          rxAct <= 1'b0;
          rxValid <= 1'b1;
        end
      end else begin
        rxTmr <= 32'(rxTmr - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ### sdipm_poll_properties.sv
// sdipm_poll_properties: port checks of the poll master
// assumes binding to sdipm_poll
`timescale 1ns/10ps
`default_nettype none
module sdipm_poll_checker
  import sdipm_pkg::*;
(
  // clock, reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // wire, supply
  input wire logic sdiOut,
  input wire logic sdiOe,
  input wire logic sensorPower
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rdZero_reg; // data phase of a zero read
  logic wrCtrl_reg; // data phase of a control write
  logic req; // address phase taken
  assign req = hsel && hready && htrans[1];
  // note address phases
  always_ff @(posedge clk) begin
    rdZero_reg <= req && !hwrite && (haddr[7:0] == OFS_CTRL || haddr[7:5] != 3'h0);
    wrCtrl_reg <= req && hwrite && haddr[7:0] == OFS_CTRL;
  end
  AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_READ_ZERO: assert property (rdZero_reg |-> hrdata == 32'h0000_0000) else $error("read not zero");
  AST_START_POWER: assert property (wrCtrl_reg && hwdata[CTRL_START] && !sensorPower |-> ##[1:3] sensorPower)
    else $error("no power on start");
  AST_DRIVE_POWERED: assert property (sdiOe |-> sensorPower) else $error("drive unpowered");
  AST_POWER_FIRST: assert property ($rose(sensorPower) |-> !sdiOe) else $error("drive at power on");
  AST_POWER_HOLD: assert property ($rose(sensorPower) |=> sensorPower [*8]) else $error("power dropped");
  AST_BREAK_FIRST: assert property ($rose(sdiOe) |=> !sdiOut [*8]) else $error("no break");
  AST_RELEASE_MARK: assert property ($fell(sdiOe) |-> $past(sdiOut)) else $error("release not mark");
  AST_OFF_RELEASED: assert property ($fell(sensorPower) |-> !sdiOe && !$past(sdiOe)) else $error("off driving");
endmodule
bind sdipm_poll sdipm_poll_checker u_chk (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .sdiOut, .sdiOe, .sensorPower);
`default_nettype wire

// ### sdipm_sensor_model.sv
// sdipm_sensor_model: behavioural sdi-12 sensor
// assumes the bench pulls the wire to marking
`timescale 1ns/10ps
`default_nettype none
module sdipm_sensor_model
  import sdipm_pkg::*;
#(
  parameter int BitCyc = 20,
  parameter int SecCyc = 200
) (
  // clock
  input wire logic clk,
  // wire
  input wire logic line,
  output logic mOut,
  output logic mOe
);
  logic [7:0] mAddr = 8'h00; // address in measure command
  logic [7:0] mIdx = 8'h00; // measure index seen
  logic early = 1'b0; // request before data ready
  int nD = 0; // data requests seen
  int cyc = 0; // free cycle count
  int readyAt = 0; // data ready cycle
  int startAt = 0; // last start edge
  // cycle count
  always @(posedge clk) cyc <= cyc + 1;
  // take one 7e1 char, lsb first
  task automatic rx(output logic [7:0] c, output logic bad);
    logic [8:0] b;
    while (line !== 1'b0) @(posedge clk);
    startAt = cyc;
    repeat (BitCyc / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BitCyc) @(posedge clk);
      b[i] = line;
    end
    c = {1'b0, b[6:0]};
    bad = !b[8] || ^b[7:0];
    while (line !== 1'b1) @(posedge clk);
  endtask
  // send one reply string
  task automatic reply(input string s);
    logic [9:0] f;
    logic [7:0] b8;
    mOe <= 1'b1;
    for (int k = 0; k < s.len(); k++) begin
      b8 = s[k];
      f = {1'b1, ^b8[6:0], b8[6:0], 1'b0};
      for (int i = 0; i < 10; i++) begin
        mOut <= f[i];
        repeat (BitCyc) @(posedge clk);
      end
    end
    mOe <= 1'b0;
  endtask
  // parse commands, answer on '!'
  initial begin
    string cmd;
    logic [7:0] c;
    logic bad;
    int n;
    mOut = 1'b1;
    mOe = 1'b0;
    cmd = "";
    forever begin
      rx(c, bad);
      if (bad && startAt + BitCyc < readyAt) early = 1'b1;
      cmd = bad ? "" : $sformatf("%s%c", cmd, c);
      n = cmd.len();
      if (!bad && c == CH_BANG && n >= 3) begin
        repeat (2 * BitCyc) @(posedge clk);
        if (cmd[n-3] == CH_D) begin
          nD++;
          reply(cmd[n-2] == CH_ZERO ? $sformatf("%c+1.5-22.25\r\n", cmd[n-4]) : $sformatf("%c+3\r\n", cmd[n-4]));
        end else begin
          mIdx = cmd[n-2] == CH_M ? {1'b0, CH_ZERO} : cmd[n-2];
          mAddr = cmd[n-2] == CH_M ? cmd[n-3] : cmd[n-4];
          reply($sformatf("%c0013\r\n", mAddr));
          readyAt = cyc + SecCyc;
        end
        cmd = "";
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_sdi12_sensor_poll_master.sv
// tb_sdi12_sensor_poll_master: self-checking bench
// assumes the sensor model and a marking pull on the wire
`timescale 1ns/10ps
`default_nettype none
module tb_sdi12_sensor_poll_master
  import sdipm_pkg::*;
;
  localparam int StepC = 30; // short pre-power step
  localparam int SecC = 200; // short second
  logic clk, rst, hsel, hwrite, sdiOut, sdiOe, sensorPower, mOut, mOe, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire logic sdiLine; // resolved wire
  int n_errors = 0;
  int comparisons = 0;
  int expRes[4] = '{default: 0}; // expected per slot
  int vals[$] = '{1500, -22250, 3000}; // sensor values, thousandths
  assign sdiLine = sdiOe ? sdiOut : (mOe ? mOut : 1'b1);
  sdipm_poll #(.BitCyc(20), .BreakCyc(300), .MarkCyc(50), .StepCyc(StepC), .SecCyc(SecC)) DUT (.clk, .rst,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .sdiIn(sdiLine), .sdiOut, .sdiOe, .sensorPower);
  sdipm_sensor_model #(.BitCyc(20), .SecCyc(SecC)) sensor (.clk, .line(sdiLine), .mOut, .mOe);
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // next edge with ready, bounded
  task automatic rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) chk(0, 1);
      if (k > 100) finish_test();
      @(posedge clk);
    end
  endtask
  // one single transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  // main sequence
  initial begin
    int pre, pc, k, nd0, ri, res, ad, mi;
    logic seen;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    rst = 1'b1;
    void'($urandom(32'h959f_8744));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(0, OFS_CFG, 0);
    chk(rd, {8'h00, CFG_RST});
    bus(1, OFS_CFG, 32'h00c1_234b);
    bus(0, OFS_CFG, 0);
    chk(rd, 32'h00c1_2340);
    bus(0, 8'h40, 0);
    chk(rd, 0);
    $display("setup test done");
    for (int i = 0; i < 5; i++) begin
      ad = $urandom_range(9);
      mi = $urandom_range(9);
      res = $urandom_range(3);
      ri = (i == 4) ? 4 : $urandom_range(3, 1);
      pre = (i == 0) ? 255 : $urandom_range(2);
      nd0 = sensor.nD;
      chk(sensorPower, 0);
      bus(1, OFS_CFG, {8'h00, 2'(i), 2'(res), 4'(ri), 8'(pre), 4'(mi), 4'(ad)});
      bus(1, OFS_CTRL, 32'h0000_0001);
      pc = 0;
      seen = 0;
      k = 0;
      while (k < 60000 && !(seen && !sensorPower)) begin
        @(posedge clk);
        k++;
        if (sdiOe) seen = 1;
        else if (!seen && sensorPower) pc++;
      end
      chk(k < 60000, 1);
      if (k >= 60000) finish_test();
      if (ri < 4) expRes[i % 4] = vals[ri - 1] / (10 ** (3 - res));
      chk(pc + 1 >= pre * StepC && pc <= pre * StepC + 4, 1);
      chk(sensor.mAddr, CH_ZERO + ad);
      chk(sensor.mIdx, CH_ZERO + mi);
      chk(sensor.nD - nd0, 2);
      chk(sensor.early, 0);
      bus(0, OFS_STAT, 0);
      chk(rd, 32'h0000_0102 | ((ri > 3) << 2));
      for (int s = 0; s < 4; s++) begin
        bus(0, OFS_RES + 8'(4 * s), 0);
        chk(rd, expRes[s]);
      end
      bus(1, OFS_STAT, 32'h0000_000e);
      $display("poll %0d done", i);
    end
    finish_test();
  end
endmodule
`default_nettype wire
